// ### rtl/program_space_access_unit.sv
// What this block does
// - low table ops move program bits 15..0
// - high table ops alone reach bits 23..16
// - program address steps two per word
// - low byte read picks byte by select
// - high word read zeroes data 15..8
// - high byte read lands in data 7..0
// - phantom byte select reads zero
// - table address is page above ea
// - page msb selects configuration space
// - configuration space read only, writes refused
// - unaligned table addresses raise no fault
// - visibility needs ea msb and enable
// - visibility page plus ea 14..0
// - ea 15 ignored, bit 23 zero
// - upper data half maps, low word returned
// - visibility reads fetch once, extra cycles reported
// - move one extra, others two extra
// - repeat loop edges two, else none
// - table ops suspend visibility mapping
// - rows of 64, erase blocks 512
// - table writes go to holding latches
// - table page picks 32k word region
`default_nettype none
module program_space_access_unit #(
   parameter int unsigned row_words_p = psa_pkg::row_words
)(
   // clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // ahb-lite slave
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // cpu side
   input  wire psa_pkg::cpu_req_type  cpu_req,
   output psa_pkg::cpu_resp_type      cpu_resp,
   // program flash array
   output logic      [23:0]           flash_addr,
   output logic                       flash_rd,
   input  wire logic [23:0]           flash_rdata,
   output logic                       latch_we,
   output logic      [5:0]            latch_index,
   output logic      [23:0]           latch_wdata,
   output logic      [23:0]           latch_wmask
);
   localparam int unsigned iw = $clog2(row_words_p);

   typedef enum logic [1:0]
   {
      st_idle  = 2'b00,
      st_fetch = 2'b01,
      st_done  = 2'b10
   } state_type;

   state_type       state_q;
   logic [7:0]      tblpage_q;
   logic [7:0]      psvpage_q;
   logic [15:0]     cpu_ctrl_q;
   logic [15:0]     refused_cnt_q;
   logic [15:0]     latch_cnt_q;
   psa_pkg::cpu_req_type req_q;
   logic [23:0]     addr_q;
   logic            vis_q;
   logic [23:0]     word_q;

   // bus address phase capture
   logic            ph_valid_q;
   logic            ph_write_q;
   logic [7:0]      ph_addr_q;
   logic            take;
   assign take = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_valid_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_addr_q  <= 8'h00;
      end
      else if (hready)
      begin
         ph_valid_q <= take;
         ph_write_q <= hwrite;
         ph_addr_q  <= haddr;
      end
   end

   // zero wait state, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tblpage_q  <= psa_pkg::tblpage_reset;
         psvpage_q  <= psa_pkg::psvpage_reset;
         cpu_ctrl_q <= psa_pkg::cpu_ctrl_reset;
      end
      else if (ph_valid_q && ph_write_q)
      begin
         case (ph_addr_q)
            psa_pkg::tblpage_addr:  tblpage_q  <= hwdata[7:0];
            psa_pkg::psvpage_addr:  psvpage_q  <= hwdata[7:0];
            psa_pkg::cpu_ctrl_addr: cpu_ctrl_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // read data decode, unmapped reads zero
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (ph_valid_q && !ph_write_q)
      begin
         case (ph_addr_q)
            psa_pkg::tblpage_addr:     hrdata = {24'h000000, tblpage_q};
            psa_pkg::psvpage_addr:     hrdata = {24'h000000, psvpage_q};
            psa_pkg::cpu_ctrl_addr:    hrdata = {16'h0000, cpu_ctrl_q};
            psa_pkg::status_addr:      hrdata = {16'h0000, refused_cnt_q};
            psa_pkg::latch_count_addr: hrdata = {16'h0000, latch_cnt_q};
            default:                   hrdata = 32'h0000_0000;
         endcase
      end
   end

   // request classification
   logic is_table;
   logic is_write;
   logic vis_hit;
   logic [23:0] tbl_addr;
   logic [23:0] vis_addr;
   assign is_table = cpu_req.op inside {psa_pkg::op_read_low, psa_pkg::op_read_high,
                                        psa_pkg::op_write_low, psa_pkg::op_write_high};
   assign is_write = cpu_req.op inside {psa_pkg::op_write_low, psa_pkg::op_write_high};
   assign vis_hit  = (cpu_req.op == psa_pkg::op_data_read) & cpu_req.ea[15]
                     & cpu_ctrl_q[psa_pkg::vis_enable_bit] & (state_q == st_idle);
   // page over ea, no alignment check
   assign tbl_addr = {tblpage_q, cpu_req.ea};
   // page bit 0 lands at bit 15
   assign vis_addr = {1'b0, psvpage_q, cpu_req.ea[14:0]};

   function automatic logic [1:0] penalty(input psa_pkg::cpu_req_type r);
      if (r.in_repeat)
         penalty = r.rep_edge ? psa_pkg::penalty_other : psa_pkg::penalty_none;
      else
         penalty = r.is_move ? psa_pkg::penalty_move : psa_pkg::penalty_other;
   endfunction

   logic refuse;
   assign refuse = is_write & tblpage_q[psa_pkg::config_space_bit];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= st_idle;
         req_q   <= '0;
         addr_q  <= 24'h000000;
         vis_q   <= 1'b0;
         word_q  <= 24'h000000;
      end
      else
      begin
         case (state_q)
            st_idle:
            begin
               if ((is_table && !is_write) || vis_hit)
               begin
                  req_q   <= cpu_req;
                  addr_q  <= vis_hit ? vis_addr : tbl_addr;
                  vis_q   <= vis_hit;
                  state_q <= st_fetch;
               end
            end
            st_fetch:
            begin
               word_q  <= flash_rdata;
               state_q <= st_done;
            end
            st_done:
               state_q <= st_idle;
            default:
               state_q <= st_idle;
         endcase
      end
   end

   // flash read strobe during fetch
   assign flash_addr = addr_q;
   assign flash_rd   = (state_q == st_fetch);

   // read data formatting
   function automatic logic [15:0] format(input psa_pkg::cpu_req_type r,
                                          input logic vis, input logic [23:0] w);
      if (vis || r.op == psa_pkg::op_read_low)
      begin
         if (!vis && r.byte_mode)
            format = {8'h00, r.ea[0] ? w[15:8] : w[7:0]};
         else
            format = w[15:0];
      end
      else
      begin
         if (r.byte_mode && r.ea[0])
            format = 16'h0000;
         else
            format = {8'h00, w[23:16]};
      end
   endfunction

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cpu_resp <= '0;
      else
      begin
         cpu_resp.valid   <= 1'b0;
         cpu_resp.refused <= 1'b0;
         if (state_q == st_done)
         begin
            cpu_resp.valid        <= 1'b1;
            cpu_resp.rdata        <= format(req_q, vis_q, word_q);
            cpu_resp.extra_cycles <= vis_q ? penalty(req_q) : psa_pkg::penalty_none;
         end
         else if (state_q == st_idle && is_write)
         begin
            cpu_resp.valid        <= 1'b1;
            cpu_resp.refused      <= refuse;
            cpu_resp.rdata        <= 16'h0000;
            cpu_resp.extra_cycles <= psa_pkg::penalty_none;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         latch_we    <= 1'b0;
         latch_index <= 6'h00;
         latch_wdata <= 24'h000000;
         latch_wmask <= 24'h000000;
      end
      else
      begin
         latch_we <= 1'b0;
         if (state_q == st_idle && is_write && !refuse)
         begin
            latch_we    <= 1'b1;
            latch_index <= 6'(tbl_addr[iw:1]);
            if (cpu_req.op == psa_pkg::op_write_low)
            begin
               if (!cpu_req.byte_mode)
               begin
                  latch_wdata <= {8'h00, cpu_req.wdata};
                  latch_wmask <= 24'h00FFFF;
               end
               else if (cpu_req.ea[0])
               begin
                  latch_wdata <= {8'h00, cpu_req.wdata[7:0], 8'h00};
                  latch_wmask <= 24'h00FF00;
               end
               else
               begin
                  latch_wdata <= {16'h0000, cpu_req.wdata[7:0]};
                  latch_wmask <= 24'h0000FF;
               end
            end
            else
            begin
               latch_wdata <= {cpu_req.wdata[7:0], 16'h0000};
               latch_wmask <= (cpu_req.byte_mode && cpu_req.ea[0]) ? 24'h000000
                                                                  : 24'hFF0000;
            end
         end
      end
   end

   // statistics counters, saturating is not needed at 16 bits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         refused_cnt_q <= 16'h0000;
         latch_cnt_q   <= 16'h0000;
      end
      else if (state_q == st_idle && is_write)
      begin
         if (refuse)
            refused_cnt_q <= refused_cnt_q + 16'h0001;
         else
            latch_cnt_q <= latch_cnt_q + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### rtl/psa_pkg.sv
`default_nettype none
package psa_pkg;
   // register byte addresses on the bus
   localparam logic [7:0] tblpage_addr      = 8'h00;
   localparam logic [7:0] psvpage_addr      = 8'h04;
   localparam logic [7:0] cpu_ctrl_addr     = 8'h08;
   localparam logic [7:0] status_addr       = 8'h0C;
   localparam logic [7:0] latch_count_addr  = 8'h10;
   // field positions
   localparam int unsigned vis_enable_bit   = 2;
   localparam int unsigned config_space_bit = 7;
   // reset values
   localparam logic [7:0]  tblpage_reset    = 8'h00;
   localparam logic [7:0]  psvpage_reset    = 8'h00;
   localparam logic [15:0] cpu_ctrl_reset   = 16'h0000;
   // flash geometry
   localparam int unsigned row_words        = 64;
   localparam int unsigned row_bytes        = 192;
   localparam int unsigned erase_words      = 512;
   localparam int unsigned erase_bytes      = 1536;
   // extra cycle counts for visibility accesses
   localparam logic [1:0]  penalty_move     = 2'h1;
   localparam logic [1:0]  penalty_other    = 2'h2;
   localparam logic [1:0]  penalty_none     = 2'h0;

   typedef enum logic [2:0]
   {
      op_none        = 3'b000,
      op_read_low    = 3'b001,
      op_read_high   = 3'b010,
      op_write_low   = 3'b011,
      op_write_high  = 3'b100,
      op_data_read   = 3'b101
   } op_type;

   typedef struct packed
   {
      op_type      op;
      logic        byte_mode;
      logic [15:0] ea;
      logic [15:0] wdata;
      logic        is_move;
      logic        in_repeat;
      logic        rep_edge;
   } cpu_req_type;

   typedef struct packed
   {
      logic        valid;
      logic [15:0] rdata;
      logic        refused;
      logic [1:0]  extra_cycles;
   } cpu_resp_type;
endpackage
`default_nettype wire

// ### verif/flash_model.sv
`default_nettype none
module flash_model (
   // clock
   input  wire logic        hclk,
   // array port
   input  wire logic        flash_rd,
   input  wire logic [23:0] flash_addr,
   output logic      [23:0] flash_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] last_q = 24'h5A5A5A;
   // content ignores address bit 0, so one word answers both byte selects
   function automatic logic [23:0] word_at(logic [23:0] a);
      return {a[23:16] ^ a[8:1], a[16:1] ^ 16'hA53C};
   endfunction
   always_ff @(posedge hclk)
      if (flash_rd)
         last_q <= flash_rdata;
   // released array shows the inverse, never a stale copy
   assign flash_rdata = flash_rd ? word_at(flash_addr) : ~last_q;
endmodule
`default_nettype wire

// ### verif/psa_assertions.sv
`default_nettype none
module psa_checker (
   // clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // watched ports
   input  wire psa_pkg::cpu_req_type  cpu_req,
   input  wire psa_pkg::cpu_resp_type cpu_resp,
   input  wire logic [23:0]           flash_addr,
   input  wire logic                  flash_rd,
   input  wire logic                  latch_we,
   input  wire logic                  hreadyout,
   input  wire logic                  hresp
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   psa_pkg::op_type prev_q;
   logic            fresh;
   logic            rd_op;
   logic            wr_op;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         prev_q <= psa_pkg::op_none;
      else
         prev_q <= cpu_req.op;
   // only the first cycle of a held request counts as a take
   assign fresh = cpu_req.op != psa_pkg::op_none && prev_q == psa_pkg::op_none;
   assign rd_op = cpu_req.op == psa_pkg::op_read_low || cpu_req.op == psa_pkg::op_read_high;
   assign wr_op = cpu_req.op == psa_pkg::op_write_low || cpu_req.op == psa_pkg::op_write_high;
   sequence fetch_s;
      flash_rd ##2 cpu_resp.valid;
   endsequence
   AST_BUS_OK: assert property (hreadyout && !hresp) else $error("bus wait or error seen");
   AST_READ_WALK: assert property (fresh && rd_op |-> ##1 fetch_s)
      else $error("table read walk wrong");
   AST_HIGH_WORD: assert property (fresh && cpu_req.op == psa_pkg::op_read_high
      && !cpu_req.byte_mode |-> ##3 cpu_resp.rdata[15:8] == 8'h00) else $error("upper byte set");
   AST_PHANTOM: assert property (fresh && cpu_req.op == psa_pkg::op_read_high
      && cpu_req.byte_mode && cpu_req.ea[0] |-> ##3 cpu_resp.rdata == 16'h0000)
      else $error("phantom byte nonzero");
   AST_VIS_ADDR: assert property (fresh && cpu_req.op == psa_pkg::op_data_read |-> ##1
      flash_rd && !flash_addr[23] && flash_addr[14:1] == $past(cpu_req.ea[14:1]))
      else $error("visibility address wrong");
   AST_VIS_MOVE: assert property (fresh && cpu_req.op == psa_pkg::op_data_read
      && !cpu_req.in_repeat |-> ##3 cpu_resp.valid && cpu_resp.extra_cycles ==
      ($past(cpu_req.is_move, 3) ? psa_pkg::penalty_move : psa_pkg::penalty_other))
      else $error("visibility penalty wrong");
   AST_REPEAT: assert property (fresh && cpu_req.op == psa_pkg::op_data_read
      && cpu_req.in_repeat |-> ##3 cpu_resp.extra_cycles ==
      ($past(cpu_req.rep_edge, 3) ? 2'h2 : 2'h0)) else $error("repeat penalty wrong");
   AST_WRITE_WALK: assert property (fresh && wr_op |-> ##1 cpu_resp.valid
      && (latch_we ^ cpu_resp.refused)) else $error("table write walk wrong");
   AST_REFUSE: assert property (cpu_resp.refused |-> !latch_we)
      else $error("refused write reached latches");
endmodule
bind program_space_access_unit psa_checker chk_u (.hclk(hclk), .hresetn(hresetn),
   .cpu_req(cpu_req), .cpu_resp(cpu_resp), .flash_addr(flash_addr), .flash_rd(flash_rd),
   .latch_we(latch_we), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ### verif/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {psa_pkg::op_type op; logic bm; logic [15:0] ea;
      logic mv; logic rp; logic edg; logic [1:0] ex;} row_type;
   logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, flash_rd, latch_we;
   logic [1:0]            htrans;
   logic [2:0]            hsize;
   logic [7:0]            haddr, tp_v;
   logic [31:0]           hwdata, hrdata, rd;
   logic [23:0]           flash_addr, flash_rdata, latch_wdata, latch_wmask;
   logic [5:0]            latch_index;
   psa_pkg::cpu_req_type  cpu_req;
   psa_pkg::cpu_resp_type cpu_resp, got;
   logic                  wel;
   int                    error_cnt = 0;
   int                    compares = 0;
   row_type               rows [11];
   program_space_access_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cpu_req(cpu_req), .cpu_resp(cpu_resp), .flash_addr(flash_addr), .flash_rd(flash_rd),
      .flash_rdata(flash_rdata), .latch_we(latch_we), .latch_index(latch_index),
      .latch_wdata(latch_wdata), .latch_wmask(latch_wmask));
   flash_model fm_u (.hclk(hclk), .flash_rd(flash_rd), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata));
   task automatic report_and_stop();
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(string nm, logic [31:0] ex, logic [31:0] sn);
      compares++;
      if (sn !== ex)
      begin
         $display("FAIL %s expected %h seen %h", nm, ex, sn);
         error_cnt++;
      end
   endtask
   // bounded wait on the shared ready, so a stuck slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic cpu(row_type r, logic [15:0] wd);
      int n;
      @(posedge hclk);
      cpu_req <= '{r.op, r.bm, r.ea, wd, r.mv, r.rp, r.edg};
      @(posedge hclk);
      cpu_req <= '0;
      n = 0;
      // a write answers one edge after the take, so look before waiting
      #1;
      while (cpu_resp.valid !== 1'b1 && n < 10)
      begin
         @(posedge hclk);
         #1;
         n++;
      end
      got = cpu_resp;
      wel = latch_we;
      if (n >= 10)
      begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   function automatic logic [15:0] expect_rd(row_type r);
      logic [23:0] w;
      w = fm_u.word_at(r.op == psa_pkg::op_data_read ? {1'b0, 8'h35, r.ea[14:0]} : {tp_v, r.ea});
      case (r.op)
         psa_pkg::op_read_low: return r.bm ? {8'h00, r.ea[0] ? w[15:8] : w[7:0]} : w[15:0];
         psa_pkg::op_read_high: return (r.bm && r.ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
         default: return w[15:0];
      endcase
   endfunction
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   initial
   begin
      {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, cpu_req} = '0;
      tp_v = 8'h12;
      rows = '{'{psa_pkg::op_read_low, 1'b0, 16'h1235, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_read_low, 1'b1, 16'h1235, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_read_low, 1'b1, 16'h1234, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_read_high, 1'b0, 16'h0042, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_read_high, 1'b1, 16'h0042, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_read_high, 1'b1, 16'h0043, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_read_low, 1'b0, 16'h9ABD, 1'b0, 1'b0, 1'b0, 2'h0},
         '{psa_pkg::op_data_read, 1'b0, 16'h8122, 1'b1, 1'b0, 1'b0, 2'h1},
         '{psa_pkg::op_data_read, 1'b0, 16'hC456, 1'b0, 1'b0, 1'b0, 2'h2},
         '{psa_pkg::op_data_read, 1'b0, 16'h8200, 1'b0, 1'b1, 1'b1, 2'h2},
         '{psa_pkg::op_data_read, 1'b0, 16'h8202, 1'b0, 1'b1, 1'b0, 2'h0}};
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 8'h00, 32'h0);
      check("table page reset", 32'h0, rd);
      bus(1'b0, 8'h08, 32'h0);
      check("cpu control reset", 32'h0, rd);
      bus(1'b0, 8'h20, 32'h0);
      check("unmapped read", 32'h0, rd);
      bus(1'b1, 8'h00, 32'h12);
      bus(1'b1, 8'h04, 32'h35);
      bus(1'b1, 8'h08, 32'h4);
      bus(1'b0, 8'h04, 32'h0);
      check("visibility page", 32'h35, rd);
      foreach (rows[i])
      begin
         cpu(rows[i], 16'h0000);
         check("read data", expect_rd(rows[i]), got.rdata);
         check("extra cycles", rows[i].ex, got.extra_cycles);
      end
      cpu('{psa_pkg::op_write_low, 1'b0, 16'h0046, 1'b0, 1'b0, 1'b0, 2'h0}, 16'hBEEF);
      check("low write data", 32'hBEEF, latch_wdata[15:0]);
      check("latch index", 32'h23, latch_index);
      check("low write mask", 32'h00FFFF, latch_wmask);
      cpu('{psa_pkg::op_write_high, 1'b0, 16'h0046, 1'b0, 1'b0, 1'b0, 2'h0}, 16'h00A7);
      check("high write data", 32'hA7, latch_wdata[23:16]);
      check("high write mask", 32'hFF0000, latch_wmask);
      bus(1'b0, 8'h10, 32'h0);
      check("latch write count", 32'h2, rd);
      bus(1'b1, 8'h00, 32'h80);
      tp_v = 8'h80;
      cpu('{psa_pkg::op_write_low, 1'b0, 16'h0010, 1'b0, 1'b0, 1'b0, 2'h0}, 16'h1111);
      check("config write refused", 32'h2, {got.refused, wel});
      bus(1'b0, 8'h0C, 32'h0);
      check("refused count", 32'h1, rd);
      cpu(rows[0], 16'h0000);
      check("config read", expect_rd(rows[0]), got.rdata);
      report_and_stop();
   end
endmodule
`default_nettype wire
